/* File: logic/fsce_ctrl.sv */
// fail-safe clock exit controller with apb register access
`timescale 1ns/1ps
`default_nettype none
module fsce_ctrl #(
  parameter int OST_CYCLES = fsce_pkg::FSCE_OST_CYCLES,
  parameter int PLL_CYCLES = fsce_pkg::FSCE_PLL_CYCLES,
  parameter int MON_CYCLES = fsce_pkg::FSCE_MON_CYCLES
) (
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  input  wire fsce_pkg::fsce_mode_t       osc_mode_i,
  input  wire logic                       primary_ready_i,
  input  wire logic                       periph_clk_tick_i,
  input  wire logic                       sleep_exec_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [7:0]                 paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  output logic                            primary_enable_o,
  output fsce_pkg::fsce_src_t             clk_sel_o,
  output logic                            failsafe_o,
  output logic                            monitor_on_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fsce_pkg::fsce_state_t state, next_state;
  logic [fsce_pkg::FSCE_CNT_W-1:0] dly_cnt, next_dly_cnt;
  logic [fsce_pkg::FSCE_CNT_W-1:0] mon_cnt, next_mon_cnt;
  logic [fsce_pkg::FSCE_CTL_W-1:0] ctl, next_ctl;
  logic [fsce_pkg::FSCE_CTL_W-1:0] ctl_pend, next_ctl_pend;
  logic                            ctl_written, next_ctl_written;
  logic                            startup_done, next_startup_done;
  logic                            wr_fire, rd_fire;
  logic [fsce_pkg::FSCE_CNT_W-1:0] dly_target;
  logic                            delay_done, clock_lost, pm_entry;
  logic [31:0]                     next_prdata;
  logic                            next_pready, next_pslverr;
  fsce_pkg::fsce_status_t          stat;

  // ----------------------------------------------------------------
  // apb handshake and start-up decode
  // ----------------------------------------------------------------
  // apb: one wait state, answer is registered in the access phase
  assign wr_fire = psel_i & penable_i & pwrite_i & ~pready_o;
  assign rd_fire = psel_i & penable_i & ~pwrite_i & ~pready_o;

  // delay required by the configured oscillator mode
  always_comb
  begin
    case (osc_mode_i)
      fsce_pkg::FSCE_MODE_OST: dly_target = fsce_pkg::FSCE_CNT_W'(OST_CYCLES);
      fsce_pkg::FSCE_MODE_PLL: dly_target = fsce_pkg::FSCE_CNT_W'(OST_CYCLES + PLL_CYCLES);
      default:                 dly_target = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // exit and timeout conditions
  // ----------------------------------------------------------------
  assign delay_done = (dly_cnt >= dly_target) & primary_ready_i;
  assign clock_lost = (mon_cnt >= fsce_pkg::FSCE_CNT_W'(MON_CYCLES));
  assign pm_entry   = sleep_exec_i & ctl_written;

  // ----------------------------------------------------------------
  // controller next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state        = state;
    next_dly_cnt      = dly_cnt;
    next_mon_cnt      = mon_cnt;
    next_startup_done = startup_done;
    case (state)
      fsce_pkg::FSCE_ST_STARTUP:
      begin
        // run from internal oscillator while waiting; may wait forever
        if (dly_cnt != {fsce_pkg::FSCE_CNT_W{1'b1}})
          next_dly_cnt = dly_cnt + 1'b1;
        if (delay_done)
        begin
          next_state        = fsce_pkg::FSCE_ST_PRIMARY;
          next_startup_done = 1'b1;
          next_mon_cnt      = '0;
        end
      end
      fsce_pkg::FSCE_ST_PRIMARY:
      begin
        // monitor counts cycles without a peripheral clock tick
        if (periph_clk_tick_i)
          next_mon_cnt = '0;
        else if (!clock_lost)
          next_mon_cnt = mon_cnt + 1'b1;
        if (clock_lost)
        begin
          next_state        = fsce_pkg::FSCE_ST_FAILSAFE;
          next_startup_done = 1'b0;
        end
      end
      default:
      begin
        // only sleep after a control write leaves fail-safe; reset is handled below
        if (pm_entry)
        begin
          next_state        = fsce_pkg::FSCE_ST_PRIMARY;
          next_startup_done = 1'b1;
          next_mon_cnt      = '0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register file next values
  // ----------------------------------------------------------------
  always_comb
  begin
    next_ctl         = ctl;
    next_ctl_pend    = ctl_pend;
    next_ctl_written = ctl_written;
    next_prdata      = prdata_o;
    next_pready      = 1'b0;
    next_pslverr     = 1'b0;
    stat.failsafe     = (state == fsce_pkg::FSCE_ST_FAILSAFE);
    stat.startup_done = startup_done;
    stat.monitor_on   = (state == fsce_pkg::FSCE_ST_PRIMARY);
    stat.src          = clk_sel_o;
    // sleep commits the pending write; a write in the same cycle stays pending
    if (pm_entry)
    begin
      next_ctl         = ctl_pend;
      next_ctl_written = 1'b0;
    end
    if (psel_i & penable_i & ~pready_o)
      next_pready = 1'b1;
    if (wr_fire)
    begin
      if (paddr_i == fsce_pkg::FSCE_OFF_CONTROL)
      begin
        // written value held aside until sleep commits it
        next_ctl_pend    = pwdata_i[fsce_pkg::FSCE_CTL_W-1:0] & fsce_pkg::FSCE_CTL_WMASK;
        next_ctl_written = 1'b1;
      end
      else if (paddr_i != fsce_pkg::FSCE_OFF_STATUS)
        next_pslverr = 1'b1;
    end
    else if (rd_fire)
    begin
      next_prdata = '0;
      if (paddr_i == fsce_pkg::FSCE_OFF_CONTROL)
      begin
        next_prdata[fsce_pkg::FSCE_CTL_W-1:0] = ctl;
        next_prdata[fsce_pkg::FSCE_BIT_STARTUP]  = startup_done;
        next_prdata[fsce_pkg::FSCE_BIT_FAILSAFE] = stat.failsafe;
      end
      else if (paddr_i == fsce_pkg::FSCE_OFF_STATUS)
        next_prdata[$bits(stat)-1:0] = stat;
      else
        next_pslverr = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      // reset ends fail-safe and restarts the primary oscillator
      state            <= fsce_pkg::FSCE_ST_STARTUP;
      dly_cnt          <= '0;
      mon_cnt          <= '0;
      startup_done     <= 1'b0;
      ctl              <= fsce_pkg::FSCE_CTL_RESET;
      ctl_pend         <= fsce_pkg::FSCE_CTL_RESET;
      ctl_written      <= 1'b0;
      prdata_o         <= '0;
      pready_o         <= 1'b0;
      pslverr_o        <= 1'b0;
      primary_enable_o <= 1'b0;
      clk_sel_o        <= fsce_pkg::FSCE_SRC_INTERNAL;
      failsafe_o       <= 1'b0;
      monitor_on_o     <= 1'b0;
    end
    else
    begin
      state            <= next_state;
      dly_cnt          <= next_dly_cnt;
      mon_cnt          <= next_mon_cnt;
      startup_done     <= next_startup_done;
      ctl              <= next_ctl;
      ctl_pend         <= next_ctl_pend;
      ctl_written      <= next_ctl_written;
      prdata_o         <= next_prdata;
      pready_o         <= next_pready;
      pslverr_o        <= next_pslverr;
      primary_enable_o <= (next_state != fsce_pkg::FSCE_ST_FAILSAFE);
      clk_sel_o        <= (next_state == fsce_pkg::FSCE_ST_PRIMARY)
                          ? fsce_pkg::FSCE_SRC_PRIMARY
                          : fsce_pkg::FSCE_SRC_INTERNAL;
      failsafe_o       <= (next_state == fsce_pkg::FSCE_ST_FAILSAFE);
      monitor_on_o     <= (next_state == fsce_pkg::FSCE_ST_PRIMARY);
    end
  end

endmodule
`default_nettype wire

/* File: pkg/fsce_pkg.sv */
// package for the fail-safe clock exit controller
package fsce_pkg;

  // oscillator mode selected by the configuration setting
  typedef enum logic [1:0] {
    FSCE_MODE_DIRECT,
    FSCE_MODE_OST,
    FSCE_MODE_PLL,
    FSCE_MODE_INTERNAL
  } fsce_mode_t;

  // system clock source selector
  typedef enum logic [0:0] {
    FSCE_SRC_INTERNAL,
    FSCE_SRC_PRIMARY
  } fsce_src_t;

  // controller states
  typedef enum logic [1:0] {
    FSCE_ST_STARTUP,
    FSCE_ST_PRIMARY,
    FSCE_ST_FAILSAFE
  } fsce_state_t;

  // register offsets (byte addresses)
  localparam logic [7:0] FSCE_OFF_CONTROL = 8'h00;
  localparam logic [7:0] FSCE_OFF_STATUS  = 8'h04;

  // oscillator control register field layout
  localparam int FSCE_CTL_W        = 8;
  localparam int FSCE_BIT_STARTUP  = 3;
  localparam int FSCE_BIT_FAILSAFE = 4;
  localparam int FSCE_BIT_SRC      = 0;
  localparam logic [FSCE_CTL_W-1:0] FSCE_CTL_RESET = 8'h00;
  localparam logic [FSCE_CTL_W-1:0] FSCE_CTL_WMASK = 8'h73;

  // start-up delays, in cycles
  localparam int FSCE_OST_CYCLES  = 1024;
  localparam int FSCE_PLL_TIME_US = 2;
  localparam int FSCE_CLK_MHZ     = 125;
  localparam int FSCE_PLL_CYCLES  = FSCE_PLL_TIME_US * FSCE_CLK_MHZ;
  // peripheral clock monitor: idle cycles before clock is deemed stopped
  localparam int FSCE_MON_CYCLES  = 64;
  localparam int FSCE_CNT_W       = 16;

  // grouped oscillator status
  typedef struct packed {
    logic      failsafe;
    logic      startup_done;
    logic      monitor_on;
    fsce_src_t src;
  } fsce_status_t;

endpackage

/* File: dv/fsce_osc_model.sv */
// model of the primary oscillator and the peripheral clock it feeds
`timescale 1ns/1ps
`default_nettype none
module fsce_osc_model #(
  parameter int READY_DLY = 2
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic en_i,
  input  wire logic stop_i,
  input  wire logic never_i,
  output logic      ready_o,
  output logic      tick_o
);
  logic [7:0] run_cnt;
  logic [7:0] next_run_cnt;
  logic       next_tick;
  // a dropped enable kills the oscillator at once, so a restart waits again
  always_comb
  begin
    next_run_cnt = !en_i ? 8'h00 : (run_cnt == 8'hff) ? run_cnt : run_cnt + 8'h01;
    next_tick = ready_o && !stop_i && !tick_o;  // stop_i models a dead clock
  end
  always_ff @(posedge clk_i)
  begin
    run_cnt <= reset_i ? 8'h00 : next_run_cnt;
    tick_o <= reset_i ? 1'b0 : next_tick;
  end
  assign ready_o = !never_i && (run_cnt >= 8'(READY_DLY));
endmodule
`default_nettype wire

/* File: dv/fsce_chk_sva.sv */
// assertion checker for the fail-safe clock exit controller
`timescale 1ns/1ps
`default_nettype none
module fsce_chk #(
  parameter int OST_CYCLES = 8,
  parameter int PLL_CYCLES = 4,
  parameter int MON_CYCLES = 8
) (
  input wire logic                 clk_i, reset_i, primary_ready_i, periph_clk_tick_i,
  input wire logic                 sleep_exec_i, psel_i, penable_i, pready_o, pslverr_o,
  input wire logic                 primary_enable_o, failsafe_o, monitor_on_o,
  input wire fsce_pkg::fsce_mode_t osc_mode_i,
  input wire fsce_pkg::fsce_src_t  clk_sel_o
);
  logic [15:0] idle_cnt, next_idle_cnt, up_cnt, next_up_cnt;
  int          tgt;
  // ----------------------------------------
  // idle monitor cycles and cycles since reset
  // ----------------------------------------
  always_comb
  begin
    next_idle_cnt = (monitor_on_o && !periph_clk_tick_i) ? idle_cnt + 16'h1 : 16'h0;
    next_up_cnt = (up_cnt == 16'hffff) ? up_cnt : up_cnt + 16'h1;
    tgt = (osc_mode_i == fsce_pkg::FSCE_MODE_OST) ? OST_CYCLES :
          (osc_mode_i == fsce_pkg::FSCE_MODE_PLL) ? OST_CYCLES + PLL_CYCLES : 0;
  end
  always_ff @(posedge clk_i)
  begin
    idle_cnt <= reset_i ? 16'h0 : next_idle_cnt;
    up_cnt <= reset_i ? 16'h0 : next_up_cnt;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_rel_enable: assert property (!reset_i && $past(reset_i) |=> primary_enable_o)
    else $error("primary not started after reset");
  a_rst_internal: assert property ($past(reset_i) |-> !failsafe_o && !clk_sel_o)
    else $error("reset did not leave internal source");
  a_startup_wait: assert property ($rose(clk_sel_o) && !$past(failsafe_o) |-> up_cnt >= tgt)
    else $error("switched before start-up delay");
  a_switch_ready: assert property ($rose(clk_sel_o) && !$past(failsafe_o) |-> $past(primary_ready_i))
    else $error("switched while primary not ready");
  a_primary_mon: assert property (clk_sel_o |-> monitor_on_o && !failsafe_o)
    else $error("primary source without monitor");
  a_fs_internal: assert property (failsafe_o |-> !clk_sel_o && !primary_enable_o)
    else $error("fail-safe not on internal source");
  a_fs_persist: assert property (failsafe_o && !sleep_exec_i |=> failsafe_o)
    else $error("fail-safe ended without exit path");
  a_exit_resume: assert property ($fell(failsafe_o) && !$past(reset_i) |-> monitor_on_o)
    else $error("monitor idle after fail-safe exit");
  a_mon_timeout: assert property (idle_cnt >= MON_CYCLES |-> ##[0:2] failsafe_o)
    else $error("stopped clock not caught");
  a_apb_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("apb answer late");
  c_fs_in: cover property ($rose(failsafe_o));
  c_fs_out: cover property ($fell(failsafe_o) && !$past(reset_i));
  c_apb_err: cover property (pready_o && pslverr_o);
endmodule
bind fsce_ctrl fsce_chk #(.OST_CYCLES(OST_CYCLES), .PLL_CYCLES(PLL_CYCLES),
  .MON_CYCLES(MON_CYCLES)) chk_u (.clk_i, .reset_i, .primary_ready_i, .periph_clk_tick_i,
  .sleep_exec_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .primary_enable_o,
  .failsafe_o, .monitor_on_o, .osc_mode_i, .clk_sel_o);
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the fail-safe clock exit controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic                 clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic                 sleep_exec_i, primary_ready_i, periph_clk_tick_i, primary_enable_o;
  logic                 failsafe_o, monitor_on_o, stop, never, err;
  logic [7:0]           paddr_i;
  logic [31:0]          pwdata_i, prdata_o, rd;
  fsce_pkg::fsce_mode_t osc_mode_i;
  fsce_pkg::fsce_src_t  clk_sel_o;
  int                   n_errors, compares, cyc;
  fsce_ctrl #(.OST_CYCLES(8), .PLL_CYCLES(4), .MON_CYCLES(8)) dut_u (.clk_i, .reset_i,
    .osc_mode_i, .primary_ready_i, .periph_clk_tick_i, .sleep_exec_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .primary_enable_o,
    .clk_sel_o, .failsafe_o, .monitor_on_o);
  fsce_osc_model osc_u (.clk_i, .reset_i, .en_i(primary_enable_o), .stop_i(stop),
    .never_i(never), .ready_o(primary_ready_i), .tick_o(periph_clk_tick_i));
  // ----------------------------------------
  // bus cycles, start-up and verdict
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);  // pready_o ends this; only the timeout ends a hang
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic boot(input fsce_pkg::fsce_mode_t m, input int tgt, input logic [31:0] st);
    int n;
    reset_i <= 1'b1;
    osc_mode_i <= m;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    n = 0;
    while (clk_sel_o !== fsce_pkg::FSCE_SRC_PRIMARY && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    `CHK("delay", n >= tgt, 1'b1)
    apb(1'b0, fsce_pkg::FSCE_OFF_STATUS, 32'h0);
    `CHK("status", rd, st)
  endtask
  task automatic wait_fs(input logic [31:0] st);
    repeat (20) @(posedge clk_i);  // covers the monitor timeout and any exit
    `CHK("fs", failsafe_o, st[0])
    `CHK("mon", monitor_on_o, st[1])
  endtask
  task automatic final_report();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report();
    end
  end
  initial
  begin
    {reset_i, psel_i, penable_i, pwrite_i, sleep_exec_i, stop, never} = 7'h40;
    {paddr_i, pwdata_i, n_errors, compares, cyc} = '0;
    osc_mode_i = fsce_pkg::FSCE_MODE_OST;
    boot(fsce_pkg::FSCE_MODE_OST, 8, 32'h7);
    apb(1'b0, fsce_pkg::FSCE_OFF_CONTROL, 32'h0);
    `CHK("ctl_flag", rd & 32'h8, 32'h8)
    stop <= 1'b1;
    wait_fs(32'h1);
    `CHK("fs_sel", clk_sel_o, fsce_pkg::FSCE_SRC_INTERNAL)
    `CHK("fs_pri", primary_enable_o, 1'b0)
    sleep_exec_i <= 1'b1;
    @(posedge clk_i) sleep_exec_i <= 1'b0;
    wait_fs(32'h1);
    stop <= 1'b0;
    apb(1'b1, fsce_pkg::FSCE_OFF_CONTROL, 32'h73);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", err, 1'b1)
    apb(1'b0, fsce_pkg::FSCE_OFF_CONTROL, 32'h0);
    `CHK("ctl_held", rd & 32'h63, 32'h0)
    sleep_exec_i <= 1'b1;
    @(posedge clk_i) sleep_exec_i <= 1'b0;
    wait_fs(32'h2);
    apb(1'b0, fsce_pkg::FSCE_OFF_CONTROL, 32'h0);
    `CHK("ctl_commit", rd & 32'h63, 32'h63)
    stop <= 1'b1;
    wait_fs(32'h1);
    stop <= 1'b0;
    boot(fsce_pkg::FSCE_MODE_DIRECT, 0, 32'h7);
    apb(1'b0, fsce_pkg::FSCE_OFF_CONTROL, 32'h0);
    `CHK("ctl_reset", rd & 32'h72, 32'h0)
    apb(1'b1, fsce_pkg::FSCE_OFF_STATUS, 32'hf);
    `CHK("st_ro", err, 1'b0)
    boot(fsce_pkg::FSCE_MODE_PLL, 12, 32'h7);
    boot(fsce_pkg::FSCE_MODE_INTERNAL, 0, 32'h7);
    never <= 1'b1;
    boot(fsce_pkg::FSCE_MODE_OST, 0, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
